// ### include/pohc_pkg.sv
// Constants for the pin output and hold control block.
// Assumes one 200 MHz clock and a register port driven by the command interpreter.
package pohc_pkg;
   // ==========================================
   // Geometry
   localparam int unsigned LINES = 20;
   localparam int unsigned HOLD_LINES = 13;
   localparam int unsigned HOLD_W = 13;
   localparam int unsigned PWM_W = 10;
   localparam int unsigned IDX_W = 5;
   localparam logic [19:0] TH_MAP_MASK = 20'h07FFF;
   localparam logic [19:0] SMT_MAP_MASK = 20'hFFFFF;
   // ==========================================
   // Register indices
   localparam logic [4:0] IDX_BLINK = 5'h00;
   localparam logic [4:0] IDX_PULL_EN = 5'h01;
   localparam logic [4:0] IDX_PULL_DIR = 5'h02;
   localparam logic [4:0] IDX_DRIVE = 5'h03;
   localparam logic [4:0] IDX_AREF = 5'h04;
   localparam logic [4:0] IDX_PWM_A = 5'h05;
   localparam logic [4:0] IDX_PWM_B = 5'h06;
   localparam logic [4:0] IDX_OUT_WORD = 5'h07;
   localparam logic [4:0] IDX_OUT_MASK = 5'h08;
   localparam logic [4:0] IDX_HOLD0 = 5'h09;
   localparam logic [4:0] IDX_HOLD_LAST = 5'h15;
   // ==========================================
   // Reset values and hold limit
   localparam logic [7:0] RST_BLINK = 8'h00;
   localparam logic [19:0] RST_PULL_EN = 20'h00000;
   localparam logic [19:0] RST_PULL_DIR = 20'h00000;
   localparam logic [19:0] RST_DRIVE = 20'h00000;
   localparam logic RST_AREF = 1'b1;
   localparam logic [9:0] RST_PWM = 10'h000;
   localparam logic [19:0] RST_OUT_MASK = 20'hFFFFF;
   localparam logic [12:0] RST_HOLD = 13'h0000;
   localparam logic [12:0] HOLD_MAX = 13'h1770;
   // ==========================================
   // Timing
   localparam int unsigned CLK_KHZ = 200000;
   localparam int unsigned TICK10_MS = 10;
   localparam int unsigned TICK10_CYCLES = TICK10_MS * CLK_KHZ;
   localparam int unsigned BLINK_DEFAULT_MS = 250;
   localparam logic [7:0] BLINK_DEFAULT_TICKS = 8'(BLINK_DEFAULT_MS / TICK10_MS);
   localparam int unsigned HOLD_UNIT_MS = 100;
   localparam logic [3:0] TICKS_PER_HOLD_UNIT = 4'(HOLD_UNIT_MS / TICK10_MS);
   // ==========================================
   // Map bit to line number
   localparam logic [4:0] BIT_TO_LINE [LINES] = '{
      5'h04, 5'h03, 5'h02, 5'h01, 5'h00, 5'h06, 5'h08, 5'h0E, 5'h05, 5'h09,
      5'h0C, 5'h0A, 5'h0B, 5'h07, 5'h0D, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13};
endpackage

// ### logic/pohc_top.sv
// Pin output and hold control: blink timer, pull and drive maps, PWM, masked outputs.
// Assumes the command interpreter and per-line function decode share clk_i.
//
// Operation
// - Joined and indicator enabled: blink with equal halves, 250 ms when setting zero.
// - Non-zero blink setting gives half-period of setting times 10 ms.
// - Pull resistors only on lines configured as digital inputs.
// - Pull-enable map bit 1 enables the line's resistor, 0 disables.
// - Map bits 0-9 are lines 4,3,2,1,0,6,8,data-in,5,9.
// - Per-line maps are 15 bits on through-hole, 20 on surface-mount.
// - Enabled resistor pulls up for direction bit 1, down for 0.
// - Drive bit set gives 6 mA, clear 2 mA; map resets to zero.
// - Analog reference 0 selects 1.25 V, 1 selects 2.5 V, default 1.
// - Line 10 PWM function outputs duty from first 10-bit setting.
// - Line 11 PWM function outputs duty from second 10-bit setting.
// - Output-level word drives line n from bit n, bits 0 to 19 on surface-mount, 0 to 14 on through-hole.
// - Output-level bit applies only where output mask bit is set.
// - Level held for hold time in 100 ms units, then reverts to default.
// - Lines 0 to 12 each own an independent hold-time setting.
// - Hold time zero keeps the written level indefinitely.
`timescale 1ns/1ps
module pohc_top #(
   parameter int unsigned TICK10_CYCLES = pohc_pkg::TICK10_CYCLES
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic smt_variant_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [4:0] reg_index_i,
   input wire logic [19:0] reg_wdata_i,
   output logic [19:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic network_joined_i,
   input wire logic indicator_pin_function_i,
   input wire logic line10_function_i,
   input wire logic line11_function_i,
   input wire logic [19:0] line_digital_in_i,
   input wire logic [19:0] line_default_high_i,
   output logic association_indicator_line_o,
   output logic pwm_a_output_o,
   output logic pwm_b_output_o,
   output logic analog_reference_select_o,
   output logic [19:0] pull_enable_o,
   output logic [19:0] pull_up_o,
   output logic [19:0] drive_6ma_o,
   output logic [19:0] line_level_o
);
   localparam int unsigned PRE_W = $clog2(TICK10_CYCLES + 1);

   // ==========================================
   // Register file
   logic [7:0] indicator_blink_time_r;
   logic [19:0] pull_enable_map_r;
   logic [19:0] pull_direction_map_r;
   logic [19:0] drive_strength_map_r;
   logic analog_reference_select_r;
   logic [9:0] pwm_a_duty_r;
   logic [9:0] pwm_b_duty_r;
   logic [19:0] output_mask_r;
   logic [12:0] hold_time_r [pohc_pkg::HOLD_LINES];
   logic [19:0] map_mask;
   logic [19:0] map_wdata;
   logic out_word_wr;

   assign map_mask = smt_variant_i ? pohc_pkg::SMT_MAP_MASK : pohc_pkg::TH_MAP_MASK;
   assign map_wdata = reg_wdata_i & map_mask;
   assign out_word_wr = reg_wr_i && (reg_index_i == pohc_pkg::IDX_OUT_WORD);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         indicator_blink_time_r <= pohc_pkg::RST_BLINK;
         pull_enable_map_r <= pohc_pkg::RST_PULL_EN;
         pull_direction_map_r <= pohc_pkg::RST_PULL_DIR;
         drive_strength_map_r <= pohc_pkg::RST_DRIVE;
         analog_reference_select_r <= pohc_pkg::RST_AREF;
         pwm_a_duty_r <= pohc_pkg::RST_PWM;
         pwm_b_duty_r <= pohc_pkg::RST_PWM;
         output_mask_r <= pohc_pkg::RST_OUT_MASK;
      end else if (reg_wr_i) begin
         case (reg_index_i)
            pohc_pkg::IDX_BLINK: indicator_blink_time_r <= reg_wdata_i[7:0];
            pohc_pkg::IDX_PULL_EN: pull_enable_map_r <= map_wdata;
            pohc_pkg::IDX_PULL_DIR: pull_direction_map_r <= map_wdata;
            pohc_pkg::IDX_DRIVE: drive_strength_map_r <= map_wdata;
            pohc_pkg::IDX_AREF: analog_reference_select_r <= reg_wdata_i[0];
            pohc_pkg::IDX_PWM_A: pwm_a_duty_r <= reg_wdata_i[9:0];
            pohc_pkg::IDX_PWM_B: pwm_b_duty_r <= reg_wdata_i[9:0];
            pohc_pkg::IDX_OUT_MASK: output_mask_r <= map_wdata;
            default: begin
            end
         endcase
      end
   end

   // Hold settings, one per line 0 to 12
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < pohc_pkg::HOLD_LINES; i++) begin
            hold_time_r[i] <= pohc_pkg::RST_HOLD;
         end
      end else begin
         for (int i = 0; i < pohc_pkg::HOLD_LINES; i++) begin
            if (reg_wr_i && (reg_index_i == pohc_pkg::IDX_HOLD0 + 5'(i))) begin
               // Out-of-range values saturate rather than exceed the longest hold
               hold_time_r[i] <= (reg_wdata_i[12:0] > pohc_pkg::HOLD_MAX) ?
                  pohc_pkg::HOLD_MAX : reg_wdata_i[12:0];
            end
         end
      end
   end

   // ==========================================
   // Read port, data one cycle after the strobe
   logic [19:0] rd_mux;

   always_comb begin
      rd_mux = 20'h00000;
      case (reg_index_i)
         pohc_pkg::IDX_BLINK: rd_mux = {12'h000, indicator_blink_time_r};
         pohc_pkg::IDX_PULL_EN: rd_mux = pull_enable_map_r & map_mask;
         pohc_pkg::IDX_PULL_DIR: rd_mux = pull_direction_map_r & map_mask;
         pohc_pkg::IDX_DRIVE: rd_mux = drive_strength_map_r & map_mask;
         pohc_pkg::IDX_AREF: rd_mux = {19'h00000, analog_reference_select_r};
         pohc_pkg::IDX_PWM_A: rd_mux = {10'h000, pwm_a_duty_r};
         pohc_pkg::IDX_PWM_B: rd_mux = {10'h000, pwm_b_duty_r};
         pohc_pkg::IDX_OUT_MASK: rd_mux = output_mask_r & map_mask;
         default: begin
            if (reg_index_i >= pohc_pkg::IDX_HOLD0 && reg_index_i <= pohc_pkg::IDX_HOLD_LAST) begin
               rd_mux = {7'h00, hold_time_r[4'(reg_index_i - pohc_pkg::IDX_HOLD0)]};
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= 20'h00000;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
         end
      end
   end

   // ==========================================
   // 10 ms and 100 ms ticks
   logic [PRE_W-1:0] pre_r;
   logic [3:0] unit_r;
   logic tick10;
   logic tick100;

   assign tick10 = (pre_r == PRE_W'(TICK10_CYCLES - 1));
   assign tick100 = tick10 && (unit_r == pohc_pkg::TICKS_PER_HOLD_UNIT - 4'h1);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pre_r <= '0;
         unit_r <= 4'h0;
      end else begin
         pre_r <= tick10 ? '0 : pre_r + PRE_W'(1);
         if (tick100) begin
            unit_r <= 4'h0;
         end else if (tick10) begin
            unit_r <= unit_r + 4'h1;
         end
      end
   end

   // ==========================================
   // Association indicator blink
   logic [7:0] blink_cnt_r;
   logic blink_r;
   logic blink_run;
   logic [7:0] half_ticks;

   assign blink_run = indicator_pin_function_i && network_joined_i;
   assign half_ticks = (indicator_blink_time_r == 8'h00) ?
      pohc_pkg::BLINK_DEFAULT_TICKS : indicator_blink_time_r;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         blink_cnt_r <= 8'h00;
         blink_r <= 1'b0;
      end else if (!blink_run) begin
         blink_cnt_r <= 8'h00;
         blink_r <= 1'b0;
      end else if (tick10) begin
         // Setting change takes effect at the next half-period boundary at latest
         if (blink_cnt_r + 8'h01 >= half_ticks) begin
            blink_cnt_r <= 8'h00;
            blink_r <= ~blink_r;
         end else begin
            blink_cnt_r <= blink_cnt_r + 8'h01;
         end
      end
   end

   assign association_indicator_line_o = blink_r;

   // ==========================================
   // PWM, period of 1024 clocks
   logic [9:0] pwm_cnt_r;
   logic pwm_a_r;
   logic pwm_b_r;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwm_cnt_r <= 10'h000;
         pwm_a_r <= 1'b0;
         pwm_b_r <= 1'b0;
      end else begin
         pwm_cnt_r <= pwm_cnt_r + 10'h001;
         pwm_a_r <= line10_function_i && (pwm_cnt_r < pwm_a_duty_r);
         pwm_b_r <= line11_function_i && (pwm_cnt_r < pwm_b_duty_r);
      end
   end

   assign pwm_a_output_o = pwm_a_r;
   assign pwm_b_output_o = pwm_b_r;
   assign analog_reference_select_o = analog_reference_select_r;

   // ==========================================
   // Pull and drive, map bit order to line order
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pull_enable_o <= 20'h00000;
         pull_up_o <= 20'h00000;
         drive_6ma_o <= 20'h00000;
      end else begin
         for (int b = 0; b < pohc_pkg::LINES; b++) begin
            pull_enable_o[pohc_pkg::BIT_TO_LINE[b]] <= pull_enable_map_r[b] & map_mask[b]
               & line_digital_in_i[pohc_pkg::BIT_TO_LINE[b]];
            pull_up_o[pohc_pkg::BIT_TO_LINE[b]] <= pull_direction_map_r[b];
            drive_6ma_o[pohc_pkg::BIT_TO_LINE[b]] <= drive_strength_map_r[b];
         end
      end
   end

   // ==========================================
   // Masked output control with hold timers
   logic [19:0] forced_r;
   logic [19:0] forced_level_r;
   logic [12:0] hold_cnt_r [pohc_pkg::HOLD_LINES];

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         forced_r <= 20'h00000;
         forced_level_r <= 20'h00000;
         for (int i = 0; i < pohc_pkg::HOLD_LINES; i++) begin
            hold_cnt_r[i] <= 13'h0000;
         end
      end else begin
         for (int n = 0; n < pohc_pkg::HOLD_LINES; n++) begin
            if (out_word_wr && output_mask_r[n] && map_mask[n]) begin
               forced_r[n] <= 1'b1;
               forced_level_r[n] <= reg_wdata_i[n];
               hold_cnt_r[n] <= hold_time_r[n];
            end else if (tick100 && forced_r[n] && hold_cnt_r[n] != 13'h0000) begin
               // Zero count means no timeout, so only a running count reverts
               hold_cnt_r[n] <= hold_cnt_r[n] - 13'h0001;
               if (hold_cnt_r[n] == 13'h0001) begin
                  forced_r[n] <= 1'b0;
               end
            end
         end
         // Lines 13 to 19 have no hold setting, so a written level stays
         for (int n = pohc_pkg::HOLD_LINES; n < pohc_pkg::LINES; n++) begin
            if (out_word_wr && output_mask_r[n] && map_mask[n]) begin
               forced_r[n] <= 1'b1;
               forced_level_r[n] <= reg_wdata_i[n];
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         line_level_o <= 20'h00000;
      end else begin
         for (int n = 0; n < pohc_pkg::LINES; n++) begin
            line_level_o[n] <= forced_r[n] ? forced_level_r[n] : line_default_high_i[n];
         end
      end
   end
endmodule

// ### verif/pohc_chk.sv
// Port-level checker for the pin output and hold control block.
// Assumes it is bound onto pohc_top and sees only that module's ports.
`timescale 1ns/1ps
module pohc_chk #(
   parameter int unsigned TICK10_CYCLES = 20
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic smt_variant_i,
   input wire logic reg_wr_i,
   input wire logic [4:0] reg_index_i,
   input wire logic [19:0] reg_wdata_i,
   input wire logic [19:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic network_joined_i,
   input wire logic indicator_pin_function_i,
   input wire logic line10_function_i,
   input wire logic line11_function_i,
   input wire logic [19:0] line_digital_in_i,
   input wire logic association_indicator_line_o,
   input wire logic pwm_a_output_o,
   input wire logic pwm_b_output_o,
   input wire logic analog_reference_select_o,
   input wire logic [19:0] pull_enable_o,
   input wire logic [19:0] drive_6ma_o,
   input wire logic [19:0] line_level_o
);
   logic [19:0] mask_r;
   // ====================
   // Mask shadow, only lines 13-19 are compared as they never revert
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mask_r <= 20'hFFFFF;
      end else if (reg_wr_i && reg_index_i == 5'h08) begin
         mask_r <= reg_wdata_i & {smt_variant_i ? 5'h1F : 5'h00, 15'h7FFF};
      end
   end
   // ====================
   // Properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   pull_input_only_a: assert property (
      (pull_enable_o & ~$past(line_digital_in_i)) == 20'h00000) else $error("pull on non-input");
   th_read_zero_a: assert property (
      reg_rvalid_o && !smt_variant_i |-> reg_rdata_o[19:15] == 5'h00) else $error("upper bits read");
   th_map_width_a: assert property (
      !smt_variant_i |-> pull_enable_o[19:15] == 5'h00 && drive_6ma_o[19:15] == 5'h00)
      else $error("upper map bits active");
   pwm_a_off_a: assert property (!$past(line10_function_i) |-> !pwm_a_output_o)
      else $error("pwm a active when off");
   pwm_b_off_a: assert property (!$past(line11_function_i) |-> !pwm_b_output_o)
      else $error("pwm b active when off");
   blink_idle_a: assert property (
      !$past(indicator_pin_function_i && network_joined_i) |-> !association_indicator_line_o)
      else $error("indicator active when idle");
   level_masked_a: assert property (
      reg_wr_i && reg_index_i == 5'h07 |-> ##2
      ((line_level_o ^ $past(reg_wdata_i, 2)) & mask_r & 20'hFE000) == 20'h00000)
      else $error("masked level not applied");
   aref_follow_a: assert property (
      reg_wr_i && reg_index_i == 5'h04 |-> ##2
      analog_reference_select_o == $past(reg_wdata_i[0], 2)) else $error("reference not applied");
endmodule
bind pohc_top pohc_chk #(.TICK10_CYCLES(TICK10_CYCLES)) i_pohc_chk (.clk_i(clk_i),
   .reset_n_i(reset_n_i), .smt_variant_i(smt_variant_i), .reg_wr_i(reg_wr_i),
   .reg_index_i(reg_index_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .reg_rvalid_o(reg_rvalid_o), .network_joined_i(network_joined_i),
   .indicator_pin_function_i(indicator_pin_function_i), .line10_function_i(line10_function_i),
   .line11_function_i(line11_function_i), .line_digital_in_i(line_digital_in_i),
   .association_indicator_line_o(association_indicator_line_o),
   .pwm_a_output_o(pwm_a_output_o), .pwm_b_output_o(pwm_b_output_o),
   .analog_reference_select_o(analog_reference_select_o), .pull_enable_o(pull_enable_o),
   .drive_6ma_o(drive_6ma_o), .line_level_o(line_level_o));

// ### verif/pohc_ext.sv
// External circuit model: duty meter on both PWM pins, half-period meter on the indicator.
// Assumes the same clock as the block; free-running, no reset needed.
`timescale 1ns/1ps
module pohc_ext (
   input wire logic clk_i,
   input wire logic pwm_a_i,
   input wire logic pwm_b_i,
   input wire logic blink_i,
   output logic [10:0] high_a_o,
   output logic [10:0] high_b_o,
   output logic [15:0] half_o
);
   logic [9:0] win_r = 10'h000;
   logic [10:0] ca_r = 11'h000;
   logic [10:0] cb_r = 11'h000;
   logic [15:0] run_r = 16'h0000;
   logic blink_r = 1'b0;
   // ====================
   // Window of one full PWM period, so any phase gives the exact count
   always @(posedge clk_i) begin
      win_r <= win_r + 10'h001;
      ca_r <= (win_r == 10'h3FF) ? 11'h000 : ca_r + 11'(pwm_a_i);
      cb_r <= (win_r == 10'h3FF) ? 11'h000 : cb_r + 11'(pwm_b_i);
      if (win_r == 10'h3FF) begin
         high_a_o <= ca_r + 11'(pwm_a_i);
         high_b_o <= cb_r + 11'(pwm_b_i);
      end
      blink_r <= blink_i;
      run_r <= (blink_i != blink_r) ? 16'h0001 : run_r + 16'h0001;
      if (blink_i != blink_r) begin
         half_o <= run_r;
      end
   end
endmodule

// ### verif/tb.sv
// Self-checking bench for the pin output and hold control block.
// Assumes a 10 ms tick shortened to 20 cycles; register reads checked from a queue.
`timescale 1ns/1ps
module tb;
   logic clk_i = 0, reset_n_i = 0, smt_variant_i = 1, reg_wr_i = 0, reg_rd_i = 0;
   logic network_joined_i = 0, indicator_pin_function_i = 0;
   logic line10_function_i = 0, line11_function_i = 0;
   logic [4:0] reg_index_i = 5'h00;
   logic [19:0] reg_wdata_i = 20'h00000, line_digital_in_i = 20'hFFFFF;
   logic [19:0] line_default_high_i = 20'h00000, dflt, reg_rdata_o;
   logic [19:0] pull_enable_o, pull_up_o, drive_6ma_o, line_level_o;
   logic reg_rvalid_o, association_indicator_line_o, pwm_a_output_o, pwm_b_output_o;
   logic analog_reference_select_o;
   logic [10:0] high_a, high_b;
   logic [15:0] half;
   logic [19:0] exp_q[$];
   int bad_count = 0, check_count = 0, cyc = 0, seed = 49;
   int lmap[20] = '{4, 3, 2, 1, 0, 6, 8, 14, 5, 9, 12, 10, 11, 7, 13, 15, 16, 17, 18, 19};
   always #2.5 clk_i = ~clk_i;
   pohc_top #(.TICK10_CYCLES(20)) i_pohc_top (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .smt_variant_i(smt_variant_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_index_i(reg_index_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .network_joined_i(network_joined_i),
      .indicator_pin_function_i(indicator_pin_function_i),
      .line10_function_i(line10_function_i), .line11_function_i(line11_function_i),
      .line_digital_in_i(line_digital_in_i), .line_default_high_i(line_default_high_i),
      .association_indicator_line_o(association_indicator_line_o),
      .pwm_a_output_o(pwm_a_output_o), .pwm_b_output_o(pwm_b_output_o),
      .analog_reference_select_o(analog_reference_select_o), .pull_enable_o(pull_enable_o),
      .pull_up_o(pull_up_o), .drive_6ma_o(drive_6ma_o), .line_level_o(line_level_o));
   pohc_ext i_pohc_ext (.clk_i(clk_i), .pwm_a_i(pwm_a_output_o), .pwm_b_i(pwm_b_output_o),
      .blink_i(association_indicator_line_o), .high_a_o(high_a), .high_b_o(high_b),
      .half_o(half));
   // ====================
   // Shared tasks
   task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] idx, input logic [19:0] d);
      @(negedge clk_i);
      reg_wr_i = 1;
      reg_index_i = idx;
      reg_wdata_i = d;
      @(negedge clk_i);
      reg_wr_i = 0;
   endtask
   task automatic rd(input logic [4:0] idx, input logic [19:0] e);
      @(negedge clk_i);
      reg_rd_i = 1;
      reg_index_i = idx;
      exp_q.push_back(e);
      @(negedge clk_i);
      reg_rd_i = 0;
   endtask
   task automatic summarize;
      if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // ====================
   // Read monitor, a read answers for one cycle only
   always @(negedge clk_i) if (reg_rvalid_o === 1'b1) check("rdata", reg_rdata_o, exp_q.pop_front());
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         summarize();
      end
   end
   // ====================
   // Main sequence
   initial begin
      dflt = 20'($random(seed));
      line_default_high_i = dflt;
      idle(4);
      reset_n_i = 1;
      check("aref", analog_reference_select_o, 20'h00001);
      for (int i = 0; i < 23; i++) rd(5'(i), i == 4 ? 20'h1 : i == 8 ? 20'hFFFFF : 20'h0);
      for (int b = 0; b < 20; b++) begin
         wr(pohc_pkg::IDX_PULL_EN, 20'h1 << b);
         wr(pohc_pkg::IDX_PULL_DIR, 20'h1 << b);
         wr(pohc_pkg::IDX_DRIVE, 20'h1 << b);
         idle(2);
         check("pull", pull_enable_o, 20'h1 << lmap[b]);
         check("up", 20'(pull_up_o[lmap[b]]), 20'h1);
         check("drive", drive_6ma_o, 20'h1 << lmap[b]);
      end
      line_digital_in_i = 20'h00000;
      idle(2);
      check("pull", pull_enable_o, 20'h0);
      wr(pohc_pkg::IDX_PULL_DIR, ~dflt);
      rd(pohc_pkg::IDX_PULL_DIR, ~dflt);
      wr(pohc_pkg::IDX_HOLD_LAST, 20'h1FFF);
      rd(pohc_pkg::IDX_HOLD_LAST, 20'h1770);
      wr(pohc_pkg::IDX_AREF, 20'h0);
      rd(pohc_pkg::IDX_AREF, 20'h0);
      wr(pohc_pkg::IDX_PWM_A, 20'h200);
      wr(pohc_pkg::IDX_PWM_B, 20'h100);
      line10_function_i = 1;
      line11_function_i = 1;
      idle(2100);
      check("pwm_a", high_a, 20'h200);
      check("pwm_b", high_b, 20'h100);
      line10_function_i = 0;
      line11_function_i = 0;
      indicator_pin_function_i = 1;
      network_joined_i = 1;
      idle(1600);
      check("blink", half, 20'h1F4);
      wr(pohc_pkg::IDX_BLINK, 20'h14);
      idle(1300);
      check("blink", half, 20'h190);
      network_joined_i = 0;
      // Line 0 holds three units, line 2 forever then one, line 1 forever, line 19 never reverts
      wr(pohc_pkg::IDX_HOLD0, 20'h3);
      wr(pohc_pkg::IDX_OUT_MASK, 20'h80007);
      wr(pohc_pkg::IDX_OUT_WORD, ~dflt);
      idle(2);
      check("level", line_level_o, dflt ^ 20'h80007);
      idle(300);
      // One-unit hold set only now, so the tick phase cannot upset the first check
      wr(5'(pohc_pkg::IDX_HOLD0 + 5'h02), 20'h1);
      wr(pohc_pkg::IDX_OUT_WORD, ~dflt);
      idle(350);
      check("level", line_level_o, dflt ^ 20'h80003);
      idle(300);
      check("level", line_level_o, dflt ^ 20'h80002);
      reset_n_i = 0;
      smt_variant_i = 0;
      idle(4);
      reset_n_i = 1;
      rd(pohc_pkg::IDX_OUT_MASK, 20'h07FFF);
      wr(pohc_pkg::IDX_DRIVE, 20'hFFFFF);
      rd(pohc_pkg::IDX_DRIVE, 20'h07FFF);
      idle(3);
      summarize();
   end
endmodule
